// ### frq_pkg.sv
package frq_pkg;
    // sizing
    localparam int NSTAGE = 8;
    localparam int NOVER = 4;
    localparam int NGROUP = 8;
    localparam int NREC = 12;
    localparam int FREQ_W = 16;
    localparam int DLY_W = 15;
    localparam int UV_W = 14;
    // timing: program cycle derived from the clock rate
    localparam int CLK_MHZ = 100;
    localparam int PROG_CYCLE_US = 1000;
    localparam int PROG_CYCLES = PROG_CYCLE_US * CLK_MHZ;
    localparam int PRETRIG_MS = 20;
    localparam int PRETRIG_TICKS = (PRETRIG_MS * 1000) / PROG_CYCLE_US;
    // frequency lsb is 0.01 Hz = 10 mHz
    localparam int FREQ_LSB_MHZ = 10;
    localparam int HYST_MHZ = 20;
    localparam logic [16:0] HYST_LSB = 17'(HYST_MHZ / FREQ_LSB_MHZ);
    localparam logic [15:0] PICKUP_OVER_RST = 16'h13EC;
    localparam logic [15:0] PICKUP_UNDER_RST = 16'h1324;
    localparam logic [14:0] DELAY_RST = 15'h0028;
    localparam logic [31:0] RATIO_SCALE = 32'h000003E8;
    localparam logic [15:0] RATIO_MAX = 16'h4E20;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STG_EN = 12'h004;
    localparam logic [11:0] OFS_FORCE = 12'h008;
    localparam logic [11:0] OFS_UV = 12'h00C;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_RATIO = 12'h014;
    localparam logic [11:0] OFS_INT_STAT = 12'h018;
    localparam logic [11:0] OFS_INT_CLR = 12'h01C;
    localparam logic [11:0] OFS_INT_EN = 12'h020;
    localparam logic [11:0] OFS_CNT_START = 12'h024;
    localparam logic [11:0] OFS_CNT_TRIP = 12'h028;
    localparam logic [11:0] OFS_CNT_BLOCK = 12'h02C;
    localparam logic [11:0] OFS_CNT_CLR = 12'h030;
    localparam logic [11:0] OFS_REC_PTR = 12'h034;
    localparam logic [11:0] OFS_REC_BASE = 12'h100;
    localparam logic [11:0] OFS_SET_BASE = 12'h200;
    // control register fields
    localparam int CTRL_ACT_BIT = 0;
    localparam int CTRL_FORCE_BIT = 1;
    localparam int CTRL_MODE_ALLOW_BIT = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_REF_LSB = 8;
    localparam int CTRL_GRP_LSB = 12;
    localparam int CTRL_RSEL_LSB = 16;
    // setting word fields
    localparam int SET_DLY_LSB = 16;
    localparam int SET_USE_BIT = 31;
    // event bits of the interrupt status
    localparam int EV_START_ON = 0;
    localparam int EV_START_OFF = 1;
    localparam int EV_TRIP_ON = 2;
    localparam int EV_TRIP_OFF = 3;
    localparam int EV_BLOCK_ON = 4;
    localparam int EV_BLOCK_OFF = 5;
    localparam int NEV = 6;
    localparam logic [3:0] REC_START = 4'h0;
    localparam logic [3:0] REC_TRIP = 4'h1;
    localparam logic [3:0] REC_BLOCK = 4'h2;
    typedef enum logic [2:0] {
        FRQ_MODE_ON = 3'h0,
        FRQ_MODE_BLOCKED = 3'h1,
        FRQ_MODE_TEST = 3'h2,
        FRQ_MODE_TEST_BLOCKED = 3'h3,
        FRQ_MODE_OFF = 3'h4
    } frq_mode_t;
    typedef enum logic [1:0] {
        FRQ_FORCE_NORMAL = 2'h0,
        FRQ_FORCE_START = 2'h1,
        FRQ_FORCE_TRIP = 2'h2,
        FRQ_FORCE_BLOCKED = 2'h3
    } frq_force_t;
endpackage : frq_pkg

// ### frq_stage.sv
module frq_stage #(
    parameter bit UNDER = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // program cycle and gating
    input wire logic tick,
    input wire logic run,
    input wire logic block_in,
    input wire logic [1:0] force_sel,
    // settings and measurement
    input wire logic [15:0] pickup,
    input wire logic [14:0] delay,
    input wire logic [15:0] freq,
    // stage condition
    output logic start_o,
    output logic trip_o,
    output logic blocked_o
);
    logic pu_ff, start_ff, trip_ff, blocked_ff;
    logic [14:0] cnt_ff;

    // pick-up with release pulled back by the hysteresis
    function automatic logic picks(input logic [15:0] f, input logic [15:0] p, input logic held);
        logic [16:0] lim;
        lim = 17'(p);
        if (UNDER) begin
            if (held) lim = lim + frq_pkg::HYST_LSB;
            picks = 17'(f) < lim;
        end else begin
            if (held) lim = lim - frq_pkg::HYST_LSB;
            picks = 17'(f) > lim;
        end
    endfunction : picks

    wire picked = picks(freq, pickup, pu_ff);
    wire nxt_blocked = picked & (blocked_ff | block_in);
    wire nxt_start = picked & ~nxt_blocked;
    wire [14:0] nxt_cnt = start_ff ? ((cnt_ff == 15'h7FFF) ? cnt_ff : cnt_ff + 15'h0001) : 15'h0000;
    wire nxt_trip = nxt_start & (nxt_cnt >= delay);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_ff <= 1'b0;
            start_ff <= 1'b0;
            trip_ff <= 1'b0;
            blocked_ff <= 1'b0;
            cnt_ff <= 15'h0000;
        end else if (!run) begin
            pu_ff <= 1'b0;
            start_ff <= 1'b0;
            trip_ff <= 1'b0;
            blocked_ff <= 1'b0;
            cnt_ff <= 15'h0000;
        end else if (tick) begin
            pu_ff <= picked;
            start_ff <= nxt_start;
            trip_ff <= nxt_trip;
            blocked_ff <= nxt_blocked;
            cnt_ff <= nxt_start ? nxt_cnt : 15'h0000;
        end
    end

    // forced condition overrides the measured one
    assign start_o = (force_sel == frq_pkg::FRQ_FORCE_START) | (force_sel == frq_pkg::FRQ_FORCE_TRIP) |
        ((force_sel == frq_pkg::FRQ_FORCE_NORMAL) & start_ff);
    assign trip_o = (force_sel == frq_pkg::FRQ_FORCE_TRIP) | ((force_sel == frq_pkg::FRQ_FORCE_NORMAL) & trip_ff);
    assign blocked_o = (force_sel == frq_pkg::FRQ_FORCE_BLOCKED) |
        ((force_sel == frq_pkg::FRQ_FORCE_NORMAL) & blocked_ff);

    a_trip_needs_start: assert property (@(posedge pclk) disable iff (!presetn)
        trip_ff |-> start_ff) else $error("trip without start");
    a_block_kills_start: assert property (@(posedge pclk) disable iff (!presetn)
        (run && tick && block_in && picked) |=> (!start_ff && blocked_ff)) else $error("block did not stop start");
    a_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
        !run |=> (!start_ff && !trip_ff && !blocked_ff)) else $error("disabled stage active");
endmodule : frq_stage

// ### frq_prot.sv
// Added by the designer: register access over APB and the register offsets.
module frq_prot #(
    parameter int PROG_CYCLES = frq_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements and blocking matrix
    input wire logic [15:0] freq_ref1,
    input wire logic [15:0] freq_ref2,
    input wire logic [15:0] freq_ref3,
    input wire logic [13:0] volt_meas,
    input wire logic [7:0] block_in,
    // stage outputs and interrupt
    output logic [7:0] start_out,
    output logic [7:0] trip_out,
    output logic [7:0] blocked_out,
    output logic irq
);
    localparam int NS = frq_pkg::NSTAGE;
    localparam int NSET = frq_pkg::NGROUP * frq_pkg::NSTAGE;
    initial begin
        if (PROG_CYCLES < 2) $error("PROG_CYCLES must be at least 2");
        if (PROG_CYCLES > 131072) $error("PROG_CYCLES must fit the 17-bit divider");
    end

    logic [31:0] ctrl_ff, force_ff;
    logic [7:0] stg_en_ff;
    logic [13:0] uv_ff;
    logic [31:0] set_mem [NSET];
    logic [31:0] rec_mem [2*frq_pkg::NREC];
    logic [15:0] pre_mem [frq_pkg::PRETRIG_TICKS];
    logic [3:0] rec_ptr_ff;
    logic [7:0] start_ff, trip_ff, blocked_ff, trip_pin_ff;
    logic [5:0] int_stat_ff, int_en_ff;
    logic [15:0] cnt_start_ff, cnt_trip_ff, cnt_block_ff, ratio_ff, stamp_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, irq_ff;
    logic [16:0] div_ff;
    logic tick_ff;

    // program cycle enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 17'h00000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == 17'(PROG_CYCLES - 1));
            div_ff <= (div_ff == 17'(PROG_CYCLES - 1)) ? 17'h00000 : div_ff + 17'h00001;
        end
    end

    // apb decode
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_ff;
    wire wr = acc & pwrite;
    wire [11:0] set_ofs = paddr - frq_pkg::OFS_SET_BASE;
    wire [11:0] rec_ofs = paddr - frq_pkg::OFS_REC_BASE;
    wire in_set = (paddr >= frq_pkg::OFS_SET_BASE) && (set_ofs < 12'(NSET * 4)) && (paddr[1:0] == 2'h0);
    wire in_rec = (paddr >= frq_pkg::OFS_REC_BASE) && (rec_ofs < 12'(frq_pkg::NREC * 8)) && (paddr[1:0] == 2'h0);
    wire [5:0] set_idx = set_ofs[7:2];
    wire [4:0] rec_idx = rec_ofs[6:2];
    wire wr_ctrl = wr && (paddr == frq_pkg::OFS_CTRL);
    wire wr_en = wr && (paddr == frq_pkg::OFS_STG_EN);
    wire wr_force = wr && (paddr == frq_pkg::OFS_FORCE);
    wire wr_uv = wr && (paddr == frq_pkg::OFS_UV);
    wire wr_iclr = wr && (paddr == frq_pkg::OFS_INT_CLR);
    wire wr_ien = wr && (paddr == frq_pkg::OFS_INT_EN);
    wire wr_cclr = wr && (paddr == frq_pkg::OFS_CNT_CLR);
    wire wr_set = wr && in_set;

    // control fields
    wire func_act = ctrl_ff[frq_pkg::CTRL_ACT_BIT];
    wire force_allow = ctrl_ff[frq_pkg::CTRL_FORCE_BIT];
    wire mode_allow = ctrl_ff[frq_pkg::CTRL_MODE_ALLOW_BIT];
    wire [2:0] mode_raw = ctrl_ff[frq_pkg::CTRL_MODE_LSB +: 3];
    wire [1:0] ref_sel = ctrl_ff[frq_pkg::CTRL_REF_LSB +: 2];
    wire [2:0] grp = ctrl_ff[frq_pkg::CTRL_GRP_LSB +: 3];
    wire [2:0] rsel = ctrl_ff[frq_pkg::CTRL_RSEL_LSB +: 3];
    wire [2:0] mode = mode_allow ? mode_raw : 3'(frq_pkg::FRQ_MODE_ON);
    wire mode_off = (mode >= 3'(frq_pkg::FRQ_MODE_OFF));
    wire mode_block = (mode == 3'(frq_pkg::FRQ_MODE_BLOCKED)) || (mode == 3'(frq_pkg::FRQ_MODE_TEST_BLOCKED));
    wire mode_test = (mode == 3'(frq_pkg::FRQ_MODE_TEST)) || (mode == 3'(frq_pkg::FRQ_MODE_TEST_BLOCKED));
    wire [15:0] freq = (ref_sel == 2'h1) ? freq_ref2 : (ref_sel == 2'h2) ? freq_ref3 : freq_ref1;
    wire uv_block = (uv_ff != 14'h0000) && (volt_meas < uv_ff);

    // stages; over stages first, then under
    // forcing is stage control too, so it waits for the function to be active
    logic [7:0] st_start, st_trip, st_blocked;
    genvar s;
    generate
        for (s = 0; s < NS; s++) begin : g_stage
            wire [31:0] cfg = set_mem[{grp, 3'(s)}];
            wire run = func_act & stg_en_ff[s] & cfg[frq_pkg::SET_USE_BIT] & ~mode_off;
            frq_stage #(.UNDER(s >= frq_pkg::NOVER)) u_stage (
                .pclk(pclk),
                .presetn(presetn),
                .tick(tick_ff),
                .run(run),
                .block_in(block_in[s] | mode_block | ((s >= frq_pkg::NOVER) & uv_block)),
                .force_sel((force_allow & func_act) ? force_ff[2*s +: 2] : 2'(frq_pkg::FRQ_FORCE_NORMAL)),
                .pickup(cfg[15:0]),
                .delay(cfg[frq_pkg::SET_DLY_LSB +: 15]),
                .freq(freq),
                .start_o(st_start[s]),
                .trip_o(st_trip[s]),
                .blocked_o(st_blocked[s])
            );
        end
    endgenerate

    // events from condition changes
    function automatic logic [4:0] popcount(input logic [7:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 8; i++) n = n + 5'(v[i]);
        popcount = n;
    endfunction : popcount

    wire [7:0] start_on = st_start & ~start_ff;
    wire [7:0] trip_on = st_trip & ~trip_ff;
    wire [7:0] block_on = st_blocked & ~blocked_ff;
    wire [5:0] ev = {|(blocked_ff & ~st_blocked), |block_on, |(trip_ff & ~st_trip), |trip_on,
        |(start_ff & ~st_start), |start_on};
    wire [5:0] nxt_int_stat = (int_stat_ff & ~(wr_iclr ? pwdata[5:0] : 6'h00)) | ev;
    wire [5:0] nxt_int_en = wr_ien ? pwdata[5:0] : int_en_ff;
    wire [7:0] any_on = start_on | trip_on | block_on;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff <= 8'h00;
            trip_ff <= 8'h00;
            blocked_ff <= 8'h00;
            trip_pin_ff <= 8'h00;
            int_stat_ff <= 6'h00;
            irq_ff <= 1'b0;
        end else begin
            start_ff <= st_start;
            trip_ff <= st_trip;
            blocked_ff <= st_blocked;
            trip_pin_ff <= mode_test ? 8'h00 : st_trip;
            int_stat_ff <= nxt_int_stat;
            irq_ff <= |(nxt_int_stat & nxt_int_en);
        end
    end

    // counters: a count arriving with the clear survives it
    function automatic logic [15:0] count_upd(input logic [15:0] c, input logic clr, input logic [4:0] inc);
        count_upd = (clr ? 16'h0000 : c) + 16'(inc);
    endfunction : count_upd

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_start_ff <= 16'h0000;
            cnt_trip_ff <= 16'h0000;
            cnt_block_ff <= 16'h0000;
        end else begin
            cnt_start_ff <= count_upd(cnt_start_ff, wr_cclr & pwdata[0], popcount(start_on));
            cnt_trip_ff <= count_upd(cnt_trip_ff, wr_cclr & pwdata[1], popcount(trip_on));
            cnt_block_ff <= count_upd(cnt_block_ff, wr_cclr & pwdata[2], popcount(block_on));
        end
    end

    // ratio f_meas / f_set in thousandths for the selected stage
    wire [15:0] rs_pick = set_mem[{grp, rsel}][15:0];
    wire [31:0] ratio_num = 32'(freq) * frq_pkg::RATIO_SCALE;
    wire [31:0] ratio_q = (rs_pick == 16'h0000) ? 32'(frq_pkg::RATIO_MAX) : ratio_num / 32'(rs_pick);
    wire [15:0] nxt_ratio = (ratio_q > 32'(frq_pkg::RATIO_MAX)) ? frq_pkg::RATIO_MAX : ratio_q[15:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_ff <= 16'h0000;
            stamp_ff <= 16'h0000;
        end else if (tick_ff) begin
            ratio_ff <= nxt_ratio;
            stamp_ff <= stamp_ff + 16'h0001;
        end
    end

    // pre-trigger history, one sample a program cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < frq_pkg::PRETRIG_TICKS; i++) pre_mem[i] <= 16'h0000;
        end else if (tick_ff) begin
            pre_mem[0] <= freq;
            for (int i = 1; i < frq_pkg::PRETRIG_TICKS; i++) pre_mem[i] <= pre_mem[i-1];
        end
    end

    // record of the lowest stage with an on event; trip outranks block, block outranks start
    logic [2:0] rec_stage;
    always_comb begin
        rec_stage = 3'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (any_on[i]) rec_stage = 3'(i);
        end
    end
    wire [3:0] rec_kind = trip_on[rec_stage] ? frq_pkg::REC_TRIP :
        block_on[rec_stage] ? frq_pkg::REC_BLOCK : frq_pkg::REC_START;
    wire [31:0] rec_w0 = {5'h00, rec_stage, rec_kind, 1'b0, grp, freq};
    wire [31:0] rec_w1 = {stamp_ff, pre_mem[frq_pkg::PRETRIG_TICKS-1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rec_ptr_ff <= 4'h0;
            for (int i = 0; i < 2 * frq_pkg::NREC; i++) rec_mem[i] <= 32'h00000000;
        end else if (|any_on) begin
            rec_mem[{rec_ptr_ff, 1'b0}] <= rec_w0;
            rec_mem[{rec_ptr_ff, 1'b1}] <= rec_w1;
            rec_ptr_ff <= (rec_ptr_ff == 4'(frq_pkg::NREC - 1)) ? 4'h0 : rec_ptr_ff + 4'h1;
        end
    end

    // software-written settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 32'h00000000;
            stg_en_ff <= 8'h00;
            force_ff <= 32'h00000000;
            uv_ff <= 14'h0000;
            int_en_ff <= 6'h00;
        end else begin
            if (wr_ctrl) ctrl_ff <= pwdata & 32'h0007737F;
            if (wr_en) stg_en_ff <= pwdata[7:0];
            if (wr_force) force_ff <= {16'h0000, pwdata[15:0]};
            if (wr_uv) uv_ff <= pwdata[13:0];
            if (wr_ien) int_en_ff <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSET; i++) begin
                set_mem[i] <= {1'b0, frq_pkg::DELAY_RST,
                    ((i % NS) < frq_pkg::NOVER) ? frq_pkg::PICKUP_OVER_RST : frq_pkg::PICKUP_UNDER_RST};
            end
        end else if (wr_set) begin
            set_mem[set_idx] <= pwdata;
        end
    end

    // read mux
    logic [31:0] rd_data;
    logic rd_err;
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (paddr == frq_pkg::OFS_CTRL) rd_data = ctrl_ff;
        else if (paddr == frq_pkg::OFS_STG_EN) rd_data = {24'h000000, stg_en_ff};
        else if (paddr == frq_pkg::OFS_FORCE) rd_data = force_ff;
        else if (paddr == frq_pkg::OFS_UV) rd_data = {18'h00000, uv_ff};
        else if (paddr == frq_pkg::OFS_STATUS) rd_data = {8'h00, blocked_ff, trip_ff, start_ff};
        else if (paddr == frq_pkg::OFS_RATIO) rd_data = {16'h0000, ratio_ff};
        else if (paddr == frq_pkg::OFS_INT_STAT) rd_data = {26'h0000000, int_stat_ff};
        else if (paddr == frq_pkg::OFS_INT_CLR) rd_data = 32'h00000000;
        else if (paddr == frq_pkg::OFS_INT_EN) rd_data = {26'h0000000, int_en_ff};
        else if (paddr == frq_pkg::OFS_CNT_START) rd_data = {16'h0000, cnt_start_ff};
        else if (paddr == frq_pkg::OFS_CNT_TRIP) rd_data = {16'h0000, cnt_trip_ff};
        else if (paddr == frq_pkg::OFS_CNT_BLOCK) rd_data = {16'h0000, cnt_block_ff};
        else if (paddr == frq_pkg::OFS_CNT_CLR) rd_data = 32'h00000000;
        else if (paddr == frq_pkg::OFS_REC_PTR) rd_data = {28'h0000000, rec_ptr_ff};
        else if (in_rec) rd_data = rec_mem[rec_idx];
        else if (in_set) rd_data = set_mem[set_idx];
        else rd_err = 1'b1;
    end

    // no wait state: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & rd_err;
            if (setup) prdata_ff <= pwrite ? 32'h00000000 : rd_data;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign start_out = start_ff;
    assign trip_out = trip_pin_ff;
    assign blocked_out = blocked_ff;
    assign irq = irq_ff;

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (irq == |(int_stat_ff & int_en_ff))) else $error("irq does not follow enabled status");
    a_set_wins_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_iclr && |ev) |=> ((int_stat_ff & $past(ev)) == $past(ev))) else $error("event lost on clear");
    a_test_hides_trip: assert property (@(posedge pclk) disable iff (!presetn)
        mode_test |=> (trip_out == 8'h00)) else $error("trip pin active in test mode");
    a_inactive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!func_act)[*2] |=> (start_ff == 8'h00 && trip_ff == 8'h00)) else $error("stage active while function off");
    a_uv_blocks_under: assert property (@(posedge pclk) disable iff (!presetn)
        (uv_block && tick_ff && force_ff == 32'h00000000) ##1 (force_ff == 32'h00000000) |=> (start_ff[7:4] == 4'h0))
        else $error("under start despite uv");
    a_apb_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held two cycles");
    a_rec_ptr_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        |any_on |=> (rec_ptr_ff == (($past(rec_ptr_ff) == 4'hB) ? 4'h0 : $past(rec_ptr_ff) + 4'h1))) else $error("record ptr");
    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        tick_ff |=> !tick_ff) else $error("program cycle tick too long");
    a_ratio_per_tick: assert property (@(posedge pclk) disable iff (!presetn)
        !tick_ff |=> $stable(ratio_ff)) else $error("ratio changed between ticks");
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");
    a_rec_on_event: assert property (@(posedge pclk) disable iff (!presetn)
        !(|any_on) |=> $stable(rec_ptr_ff)) else $error("record ptr moved without event");

    c_trip_seen: cover property (@(posedge pclk) disable iff (!presetn) |trip_on);
    c_block_seen: cover property (@(posedge pclk) disable iff (!presetn) |block_on);
    c_rec_wrap: cover property (@(posedge pclk) disable iff (!presetn) |any_on && rec_ptr_ff == 4'hB);
    c_test_trip_masked: cover property (@(posedge pclk) disable iff (!presetn) mode_test && |st_trip);
endmodule : frq_prot

// ### frq_meas_model.sv
module frq_meas_model (
    // clock
    input wire logic pclk,
    // wanted measurement conditions
    input wire logic [1:0] sel,
    input wire logic [15:0] f,
    input wire logic [7:0] blk,
    // measurement and blocking matrix outputs
    output logic [15:0] freq_ref1,
    output logic [15:0] freq_ref2,
    output logic [15:0] freq_ref3,
    output logic [7:0] block_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // unselected references sit at 50 Hz so a wrong choice is seen
    always_ff @(posedge pclk) begin
        freq_ref1 <= (sel == 2'h0) ? f : 16'h1388;
        freq_ref2 <= (sel == 2'h1) ? f : 16'h1388;
        freq_ref3 <= (sel == 2'h2) ? f : 16'h1388;
        block_in <= blk;
    end
endmodule : frq_meas_model

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] r1, r2, r3, f;
    logic [13:0] volt;
    logic [7:0] bi, blk, st, tr, bl;
    logic [1:0] sel;
    int n_errors, num_checks, cyc;
    frq_meas_model mdl (.pclk(pclk), .sel(sel), .f(f), .blk(blk), .freq_ref1(r1), .freq_ref2(r2),
        .freq_ref3(r3), .block_in(bi));
    frq_prot #(.PROG_CYCLES(PC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .freq_ref1(r1), .freq_ref2(r2), .freq_ref3(r3), .volt_meas(volt), .block_in(bi), .start_out(st),
        .trip_out(tr), .blocked_out(bl), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task ticks(input int n);
        repeat (n * PC) @(posedge pclk);
    endtask : ticks
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        f = 16'h1388; blk = 8'h00; volt = 14'h0000; sel = 2'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, frq_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        chk("set over", rd, 32'h002813EC);
        apb(1'b0, 12'h210, 32'h0);
        chk("set under", rd, 32'h00281324);
        apb(1'b0, 12'h03C, 32'h0);
        chk("unmapped", 32'(err), 32'h1);
        apb(1'b1, 12'h200, 32'h800213EC);
        apb(1'b1, frq_pkg::OFS_STG_EN, 32'h1);
        apb(1'b1, frq_pkg::OFS_INT_EN, 32'h4);
        f <= 16'h13ED;
        ticks(3);
        chk("inactive", 32'(st), 32'h0);
        apb(1'b1, frq_pkg::OFS_CTRL, 32'h1);
        repeat (PC + 2) @(posedge pclk);
        chk("start", 32'({st, tr}), 32'h0100);
        ticks(3);
        chk("trip", 32'({st, tr, irq}), 32'h0203);
        f <= 16'h13EB;
        ticks(2);
        chk("hyst hold", 32'(st), 32'h1);
        f <= 16'h13EA;
        ticks(2);
        chk("release", 32'({st, tr}), 32'h0);
        apb(1'b0, frq_pkg::OFS_INT_STAT, 32'h0);
        chk("int stat", rd, 32'h0F);
        apb(1'b0, frq_pkg::OFS_CNT_TRIP, 32'h0);
        chk("trip count", rd, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk("record 0", rd, 32'h000013ED);
        apb(1'b0, 12'h108, 32'h0);
        chk("record 1", rd, 32'h001013ED);
        apb(1'b0, frq_pkg::OFS_REC_PTR, 32'h0);
        chk("record ptr", rd, 32'h2);
        apb(1'b1, frq_pkg::OFS_INT_CLR, 32'h3F);
        apb(1'b0, frq_pkg::OFS_INT_STAT, 32'h0);
        chk("irq clear", {rd[30:0], irq}, 32'h0);
        blk <= 8'h01;
        f <= 16'h13ED;
        ticks(2);
        chk("blocked", 32'({st, bl}), 32'h01);
        apb(1'b1, frq_pkg::OFS_CTRL, 32'h00001001);
        blk <= 8'h00;
        ticks(2);
        chk("group 1 unused", 32'({st, bl}), 32'h0);
        sel <= 2'h1;
        apb(1'b1, frq_pkg::OFS_CTRL, 32'h00000101);
        ticks(2);
        chk("ref 2", 32'(st), 32'h1);
        apb(1'b1, 12'h210, 32'h80001324);
        apb(1'b1, frq_pkg::OFS_STG_EN, 32'h10);
        apb(1'b1, frq_pkg::OFS_UV, 32'h00C8);
        volt <= 14'h0064;
        f <= 16'h1323;
        ticks(2);
        chk("uv block", 32'({st, bl}), 32'h10);
        chk("disabled", 32'(st), 32'h0);
        apb(1'b0, frq_pkg::OFS_RATIO, 32'h0);
        chk("ratio", rd, 32'h3C0);
        f <= 16'h1388;
        ticks(2);
        apb(1'b1, frq_pkg::OFS_UV, 32'h0);
        f <= 16'h1323;
        ticks(2);
        chk("uv off", 32'({st, tr}), 32'h1010);
        apb(1'b1, frq_pkg::OFS_FORCE, 32'h8);
        apb(1'b1, frq_pkg::OFS_CTRL, 32'h00000103);
        ticks(2);
        chk("force trip", 32'({st[1], tr[1]}), 32'h3);
        apb(1'b1, frq_pkg::OFS_CTRL, 32'h00000127);
        ticks(2);
        chk("test mode", 32'(tr), 32'h0);
        finish_test();
    end
endmodule : tb_top
